// >>> pkg/emp_cfg.svh
// constants of the error mask and pwm output control block
`ifndef EMP_CFG_SVH
`define EMP_CFG_SVH
`define EMP_ADDR_MASK 8'h1a
`define EMP_ADDR_PWM 8'h1b
`define EMP_ADDR_ERRSTAT 8'h24
`define EMP_ADDR_WARNSTAT 8'h26
`define EMP_MASK_RESET 24'h000080
`define EMP_MASK_VALID 24'heffeff
`define EMP_PWM_RESET 26'h0000000
`define EMP_PWM_VALID 26'h3ff4000
`define EMP_BIT_LOCK 7
`define EMP_BIT_WATCHDOG 4
`define EMP_FPADJ_HI 25
`define EMP_FPADJ_LO 24
`define EMP_BIT_PEN 23
`define EMP_BAND_HI 22
`define EMP_BAND_LO 20
`define EMP_FREQ_HI 19
`define EMP_FREQ_LO 16
`define EMP_BIT_PHE 14
`define EMP_FP_MIN_TICKS 4'h9
`define EMP_SENT_OFF 3'h0
`define EMP_SENT_LONG_SEQ 3'h7
`endif

// >>> pkg/emp_pkg.sv
// types of the error mask and pwm output control block
package emp_pkg;
  typedef enum logic [1:0] {
    EMP_OUT_SPI = 2'b00,
    EMP_OUT_SENT = 2'b01,
    EMP_OUT_PWM = 2'b10
  } emp_out_t;
  typedef logic [11:0] emp_hz_t;
endpackage

// >>> pkg/emp_rom_if.sv
// lookup request and answer between control logic and carrier table
`timescale 1ns/1ns
`default_nettype none
interface emp_rom_if;
  logic [2:0] band;
  logic [3:0] code;
  logic [11:0] freqHz;
  modport ctrl (output band, output code, input freqHz);
  modport rom (input band, input code, output freqHz);
endinterface
`default_nettype wire

// >>> core/emp_freq_rom.sv
// carrier frequency table, registered read
`timescale 1ns/1ns
`default_nettype none
module emp_freq_rom
  import emp_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  emp_rom_if.rom bus
);
  // ------------------------------------------------------------
  // table, indexed by band then frequency code, in Hz
  // ------------------------------------------------------------
  localparam emp_hz_t TABLE [0:127] = '{
    12'd3125, 12'd3101, 12'd3077, 12'd3053, 12'd3030, 12'd3008, 12'd2985, 12'd2963,
    12'd2941, 12'd2920, 12'd2899, 12'd2878, 12'd2857, 12'd2837, 12'd2817, 12'd2797,
    12'd2778, 12'd2740, 12'd2703, 12'd2667, 12'd2632, 12'd2597, 12'd2564, 12'd2532,
    12'd2500, 12'd2469, 12'd2439, 12'd2410, 12'd2381, 12'd2353, 12'd2326, 12'd2299,
    12'd2273, 12'd2222, 12'd2174, 12'd2128, 12'd2083, 12'd2041, 12'd2000, 12'd1961,
    12'd1923, 12'd1887, 12'd1852, 12'd1818, 12'd1786, 12'd1754, 12'd1724, 12'd1695,
    12'd1667, 12'd1613, 12'd1563, 12'd1515, 12'd1471, 12'd1429, 12'd1389, 12'd1351,
    12'd1316, 12'd1282, 12'd1250, 12'd1220, 12'd1190, 12'd1163, 12'd1136, 12'd1111,
    12'd1087, 12'd1042, 12'd1000, 12'd962, 12'd926, 12'd893, 12'd862, 12'd833,
    12'd806, 12'd781, 12'd758, 12'd735, 12'd714, 12'd694, 12'd676, 12'd658,
    12'd641, 12'd610, 12'd581, 12'd556, 12'd532, 12'd510, 12'd490, 12'd472,
    12'd455, 12'd439, 12'd424, 12'd410, 12'd397, 12'd385, 12'd373, 12'd362,
    12'd352, 12'd333, 12'd316, 12'd301, 12'd287, 12'd275, 12'd263, 12'd253,
    12'd243, 12'd234, 12'd225, 12'd217, 12'd210, 12'd203, 12'd197, 12'd191,
    12'd185, 12'd175, 12'd166, 12'd157, 12'd150, 12'd143, 12'd137, 12'd131,
    12'd126, 12'd121, 12'd116, 12'd112, 12'd108, 12'd105, 12'd101, 12'd98
  };

  wire logic [6:0] index = {bus.band, bus.code};

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bus.freqHz <= 12'h000;
    end else begin
      bus.freqHz <= TABLE[index];
    end
  end
endmodule
`default_nettype wire

// >>> core/emp_control.sv
// error mask and pwm output control registers with output routing
//
// Operation
// - a set mask bit keeps its error flag out of the summary error bit
// - raw errors and warnings stay readable at 0x24 and 0x26 regardless of masks
// - masks suppress sent soft errors; sent hard errors ignore masks
// - mask bits occupy 23:21, 19:9, 7:0; bits 20 and 8 unused
// - mask bit 4 gates the overflow or watchdog flag
// - loss of lock is always reported as a sent hard error
// - long sequential sent: adjust field raises minimum function pulse 9 to 12 ticks
// - pwm enable drives pwm on serial output and disables sent
// - with pwm and sent both off, serial output carries spi read data
// - carrier frequency comes from band and frequency code lookup
// - hysteresis enable picks the hysteresis angle for pwm or sent output
`timescale 1ns/1ns
`default_nettype none
`include "emp_cfg.svh"
module emp_control
  import emp_pkg::*;
#(
  parameter int ANGLE_W = 16
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [25:0] regWdata,
  output logic [25:0] regRdata,
  input wire logic [23:0] errorFlags,
  input wire logic [23:0] warningFlags,
  input wire logic [2:0] sentVariantSelect,
  input wire logic sentHardIn,
  input wire logic [ANGLE_W-1:0] rawAngle,
  input wire logic [ANGLE_W-1:0] hystAngle,
  input wire logic pwmWave,
  input wire logic sentWave,
  input wire logic spiData,
  output logic serialOut,
  output logic summaryErrorBit,
  output logic sentSoftError,
  output logic sentHardError,
  output logic pwmActive,
  output logic sentActive,
  output logic [11:0] carrierFrequencyHz,
  output logic [3:0] functionPulseMinTicks,
  output logic [ANGLE_W-1:0] outputAngle,
  output logic outputHysteresisEnable
);
  generate
    if (ANGLE_W < 1 || ANGLE_W > 32) begin : g_bad_width
      $error("emp_control: ANGLE_W out of range");
    end
  endgenerate

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [23:0] errorMask;
  logic [25:0] pwmOutputControl;

  wire logic writeMask = regWrite && (regAddr == `EMP_ADDR_MASK);
  wire logic writePwm = regWrite && (regAddr == `EMP_ADDR_PWM);

  // unused and omitted bits never store, so they always read zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      errorMask <= `EMP_MASK_RESET;
    end else if (writeMask) begin
      errorMask <= regWdata[23:0] & `EMP_MASK_VALID;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pwmOutputControl <= `EMP_PWM_RESET;
    end else if (writePwm) begin
      pwmOutputControl <= regWdata & `EMP_PWM_VALID;
    end
  end

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  logic [25:0] next_regRdata;
  always_comb begin
    case (regAddr)
      `EMP_ADDR_MASK: next_regRdata = {2'b00, errorMask};
      `EMP_ADDR_PWM: next_regRdata = pwmOutputControl;
      `EMP_ADDR_ERRSTAT: next_regRdata = {2'b00, errorFlags};
      `EMP_ADDR_WARNSTAT: next_regRdata = {2'b00, warningFlags};
      default: next_regRdata = 26'h0000000;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 26'h0000000;
    end else if (regRead) begin
      regRdata <= next_regRdata;
    end
  end

  // ------------------------------------------------------------
  // error gating
  // ------------------------------------------------------------
  // flag n is gated by mask bit n, flags 8 and 20 never count; bit 4 carries the overflow or watchdog flag
  wire logic [23:0] unmaskedFlags = errorFlags & ~errorMask & `EMP_MASK_VALID;
  wire logic next_summaryErrorBit = |unmaskedFlags;
  // loss of lock is a hard event, so it never counts as soft
  wire logic [23:0] softFlags = unmaskedFlags & ~(24'h000001 << `EMP_BIT_LOCK);
  wire logic next_sentSoftError = |softFlags;
  wire logic next_sentHardError = sentHardIn || errorFlags[`EMP_BIT_LOCK];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      summaryErrorBit <= 1'b0;
      sentSoftError <= 1'b0;
      sentHardError <= 1'b0;
    end else begin
      summaryErrorBit <= next_summaryErrorBit;
      sentSoftError <= next_sentSoftError;
      sentHardError <= next_sentHardError;
    end
  end

  // ------------------------------------------------------------
  // output routing
  // ------------------------------------------------------------
  wire logic pwmOutputEnable = pwmOutputControl[`EMP_BIT_PEN];
  wire logic sentRequested = sentVariantSelect != `EMP_SENT_OFF;
  wire emp_out_t outSel = pwmOutputEnable ? EMP_OUT_PWM :
    (sentRequested ? EMP_OUT_SENT : EMP_OUT_SPI);

  logic next_serialOut;
  always_comb begin
    case (outSel)
      EMP_OUT_PWM: next_serialOut = pwmWave;
      EMP_OUT_SENT: next_serialOut = sentWave;
      EMP_OUT_SPI: next_serialOut = spiData;
      default: next_serialOut = spiData;
    endcase
  end

  wire logic [1:0] functionPulseAdjust = pwmOutputControl[`EMP_FPADJ_HI:`EMP_FPADJ_LO];
  wire logic longSequential = sentVariantSelect == `EMP_SENT_LONG_SEQ;
  // the adjustment only matters in long sequential mode
  wire logic [3:0] next_minTicks = longSequential ?
    (`EMP_FP_MIN_TICKS + {2'b00, functionPulseAdjust}) : `EMP_FP_MIN_TICKS;

  wire logic outputHysteresis = pwmOutputControl[`EMP_BIT_PHE];
  wire logic [ANGLE_W-1:0] next_outputAngle = outputHysteresis ? hystAngle : rawAngle;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      serialOut <= 1'b0;
      pwmActive <= 1'b0;
      sentActive <= 1'b0;
      functionPulseMinTicks <= `EMP_FP_MIN_TICKS;
      outputAngle <= '0;
      outputHysteresisEnable <= 1'b0;
    end else begin
      serialOut <= next_serialOut;
      pwmActive <= outSel == EMP_OUT_PWM;
      sentActive <= outSel == EMP_OUT_SENT;
      functionPulseMinTicks <= next_minTicks;
      outputAngle <= next_outputAngle;
      outputHysteresisEnable <= outputHysteresis;
    end
  end

  // ------------------------------------------------------------
  // carrier frequency lookup
  // ------------------------------------------------------------
  emp_rom_if romBus ();
  assign romBus.band = pwmOutputControl[`EMP_BAND_HI:`EMP_BAND_LO];
  assign romBus.code = pwmOutputControl[`EMP_FREQ_HI:`EMP_FREQ_LO];
  assign carrierFrequencyHz = romBus.freqHz;

  emp_freq_rom u_rom (
    .clock(clock),
    .rstn(rstn),
    .bus(romBus.rom)
  );

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  mask_gate_a: assert property (@(posedge clock) disable iff (!rstn)
    (errorFlags != 24'h000000) && ((errorFlags & ~errorMask & `EMP_MASK_VALID) == 24'h000000)
    |=> !summaryErrorBit)
    else $error("masked flag reached summary error bit");

  raw_status_a: assert property (@(posedge clock) disable iff (!rstn)
    regRead && regAddr == `EMP_ADDR_ERRSTAT |=> regRdata[23:0] == $past(errorFlags))
    else $error("error status read does not show raw flags");

  soft_hard_a: assert property (@(posedge clock) disable iff (!rstn)
    ((errorMask | ~`EMP_MASK_VALID) == 24'hffffff) && !errorFlags[`EMP_BIT_LOCK] && !sentHardIn
    |=> !sentSoftError && !sentHardError)
    else $error("fully masked flags raised a sent error");

  unused_bits_a: assert property (@(posedge clock) disable iff (!rstn)
    regRead && regAddr == `EMP_ADDR_MASK |=> regRdata[20] == 1'b0 && regRdata[8] == 1'b0)
    else $error("unused mask bits read non-zero");

  watchdog_gate_a: assert property (@(posedge clock) disable iff (!rstn)
    errorFlags[`EMP_BIT_WATCHDOG] && !errorMask[`EMP_BIT_WATCHDOG] |=> summaryErrorBit)
    else $error("unmasked watchdog flag missing from summary");

  lock_hard_a: assert property (@(posedge clock) disable iff (!rstn)
    errorFlags[`EMP_BIT_LOCK] |=> sentHardError)
    else $error("loss of lock not reported as hard error");

  pulse_adj_a: assert property (@(posedge clock) disable iff (!rstn)
    longSequential |=> functionPulseMinTicks == `EMP_FP_MIN_TICKS + {2'b00, $past(functionPulseAdjust)})
    else $error("function pulse minimum wrong in long sequential mode");

  pwm_wins_a: assert property (@(posedge clock) disable iff (!rstn)
    pwmOutputEnable |=> pwmActive && !sentActive && serialOut == $past(pwmWave))
    else $error("pwm enable did not take the serial output");

  spi_default_a: assert property (@(posedge clock) disable iff (!rstn)
    !pwmOutputEnable && !sentRequested |=> !pwmActive && !sentActive && serialOut == $past(spiData))
    else $error("serial output not spi with pwm and sent off");

  corner_freq_a: assert property (@(posedge clock) disable iff (!rstn)
    romBus.band == 3'h7 && romBus.code == 4'hf |=> carrierFrequencyHz == 12'd98)
    else $error("carrier lookup wrong at slowest setting");

  hyst_angle_a: assert property (@(posedge clock) disable iff (!rstn)
    outputHysteresis |=> outputAngle == $past(hystAngle) && outputHysteresisEnable)
    else $error("hysteresis angle not selected");

  sent_path_c: cover property (@(posedge clock) disable iff (!rstn) sentActive && sentHardError);
  pwm_path_c: cover property (@(posedge clock) disable iff (!rstn) pwmActive ##1 !pwmActive);
  masked_error_c: cover property (@(posedge clock) disable iff (!rstn)
    (errorFlags & errorMask) != 24'h000000 && !next_summaryErrorBit);
  long_seq_c: cover property (@(posedge clock) disable iff (!rstn) functionPulseMinTicks == 4'hc);
endmodule
`default_nettype wire

// >>> tb/emp_host_model.sv
// host controller model at the far side of the serial output pin
`timescale 1ns/1ns
`default_nettype none
module emp_host_model
  import emp_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic useSent,
  input wire logic serialOut,
  output logic [23:0] maskCfg,
  output logic lineLevel
);
  // ------------------------------------------------
  // configuration choice and pin sampling
  // ------------------------------------------------
  // sent hides lock loss as a spurious error, spi must see it
  assign maskCfg = useSent ? 24'h000080 : 24'h000000;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      lineLevel <= 1'b0;
    else
      lineLevel <= serialOut;
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench of the error mask and pwm output control block
`timescale 1ns/1ns
`default_nettype none
`include "emp_cfg.svh"
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin errorCnt++; $display("BAD %0t %h %h", $time, a, b); end end
module testbench
  import emp_pkg::*;
;
  logic clock = 1'b0, rstn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [25:0] regWdata = 26'h0, regRdata, rdv;
  logic [23:0] errorFlags = 24'h0, warningFlags = 24'h0, maskCfg;
  logic [2:0] sentVariantSelect = 3'h0;
  logic sentHardIn = 1'b0, pwmWave = 1'b0, sentWave = 1'b0, spiData = 1'b0;
  logic [15:0] rawAngle = 16'h1234, hystAngle = 16'habcd, outputAngle;
  logic serialOut, summaryErrorBit, sentSoftError, sentHardError, pwmActive, sentActive;
  logic outputHysteresisEnable, useSent = 1'b0, lineLevel, pwm_output_enable, snt;
  logic [11:0] carrierFrequencyHz;
  logic [3:0] functionPulseMinTicks;
  logic [18:0] tbl [6] = '{{3'h0, 4'h0, 12'hc35}, {3'h7, 4'hf, 12'h062}, {3'h2, 4'h6, 12'h7d0},
                           {3'h4, 4'h9, 12'h30d}, {3'h1, 4'h8, 12'h9c4}, {3'h5, 4'hf, 12'h16a}};
  int errorCnt = 0, cmpCount = 0, i, j;
  always #20 clock = ~clock;
  emp_control i_dut (.clock, .rstn, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .errorFlags,
    .warningFlags, .sentVariantSelect, .sentHardIn, .rawAngle, .hystAngle, .pwmWave, .sentWave, .spiData,
    .serialOut, .summaryErrorBit, .sentSoftError, .sentHardError, .pwmActive, .sentActive,
    .carrierFrequencyHz, .functionPulseMinTicks, .outputAngle, .outputHysteresisEnable);
  emp_host_model i_host (.clock, .rstn, .useSent, .serialOut, .maskCfg, .lineLevel);
  // ------------------------------------------------
  // access tasks
  // ------------------------------------------------
  task automatic wt;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [25:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    wt();
  endtask
  task automatic rd(input logic [7:0] a, output logic [25:0] d);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic flags(input logic [23:0] e);
    @(posedge clock);
    errorFlags <= e;
    wt();
  endtask
  task automatic final_report;
    $display("errors %0d compares %0d", errorCnt, cmpCount);
    if (errorCnt == 0 && cmpCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ------------------------------------------------
  // tests
  // ------------------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    `CHK(functionPulseMinTicks, 4'h9)
    rstn <= 1'b1;
    rd(`EMP_ADDR_MASK, rdv); `CHK(rdv, 26'h0000080)
    rd(`EMP_ADDR_PWM, rdv); `CHK(rdv, 26'h0)
    wr(`EMP_ADDR_MASK, 26'h3ffffff);
    rd(`EMP_ADDR_MASK, rdv); `CHK(rdv, 26'h0effeff)
    wr(8'h30, 26'h3ffffff);
    rd(8'h30, rdv); `CHK(rdv, 26'h0)
    // each flag alone except 8 and 20: unmasked it alone must raise the summary
    for (i = 0; i < 24; i++) if (i != 8 && i != 20) begin
      flags(24'h1 << i);
      wr(`EMP_ADDR_MASK, {2'b0, 24'heffeff & ~(24'h1 << i)});
      `CHK(summaryErrorBit, 1'b1)
      `CHK(sentSoftError, i != 7)
      `CHK(sentHardError, i == 7)
      wr(`EMP_ADDR_MASK, {2'b0, 24'h1 << i});
      `CHK(summaryErrorBit, 1'b0)
      `CHK(sentSoftError, 1'b0)
      `CHK(sentHardError, i == 7)
    end
    @(posedge clock);
    sentHardIn <= 1'b1;
    warningFlags <= 24'h5a0c3e;
    flags(24'h00aa55);
    `CHK(sentHardError, 1'b1)
    `CHK(sentSoftError, 1'b1)
    wr(`EMP_ADDR_MASK, 26'h0effeff);
    `CHK(summaryErrorBit, 1'b0)
    `CHK(sentSoftError, 1'b0)
    `CHK(sentHardError, 1'b1)
    rd(`EMP_ADDR_ERRSTAT, rdv); `CHK(rdv, 26'h000aa55)
    rd(`EMP_ADDR_WARNSTAT, rdv); `CHK(rdv, 26'h05a0c3e)
    @(posedge clock);
    sentHardIn <= 1'b0;
    useSent <= 1'b1;
    flags(24'h000080);
    wr(`EMP_ADDR_MASK, {2'b0, maskCfg});
    `CHK(summaryErrorBit, 1'b0)
    `CHK(sentHardError, 1'b1)
    @(posedge clock);
    useSent <= 1'b0;
    wt();
    wr(`EMP_ADDR_MASK, {2'b0, maskCfg});
    `CHK(summaryErrorBit, 1'b1)
    for (i = 0; i < 16; i++) begin
      @(posedge clock);
      sentVariantSelect <= i[2:0];
      wr(`EMP_ADDR_PWM, {2'b0, i[3], 23'h0});
      pwm_output_enable = i[3];
      snt = !pwm_output_enable && i[2:0] != 3'h0;
      `CHK({pwmActive, sentActive}, {pwm_output_enable, snt})
      for (j = 0; j < 3; j++) begin
        @(posedge clock);
        {pwmWave, sentWave, spiData} <= 3'b100 >> j;
        wt();
        `CHK(lineLevel, pwm_output_enable ? pwmWave : snt ? sentWave : spiData)
      end
    end
    for (i = 0; i < 8; i++) begin
      @(posedge clock);
      sentVariantSelect <= i[2] ? 3'h7 : 3'h6;
      wr(`EMP_ADDR_PWM, {i[1:0], 24'h0});
      `CHK(functionPulseMinTicks, i[2] ? 4'h9 + 4'(i[1:0]) : 4'h9)
    end
    for (i = 0; i < 6; i++) begin
      wr(`EMP_ADDR_PWM, {3'h1, tbl[i][18:12], 1'b0, i[0], 14'h0});
      `CHK(carrierFrequencyHz, tbl[i][11:0])
      `CHK(outputHysteresisEnable, i[0])
      `CHK(outputAngle, i[0] ? hystAngle : rawAngle)
    end
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clock);
    errorCnt++;
    final_report();
  end
endmodule
`default_nettype wire
